// ==== pac_device.sv ====
// Device end: reset defaults, start-up, power-down, back-end fault and headphone select sequencing
`timescale 1ns/1ns
`include "pac_defines.svh"
module pac_device #(
  parameter int FAULT_WAIT_CYC = `PAC_FAULT_WAIT_CYC,
  parameter int INIT_CYC       = `PAC_INIT_CYC,
  parameter int HP_STEP_CYC    = `PAC_HP_STEP_CYC
) (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_IN,
  pac_ctrl_if.dev         CTRL,
  output logic      [7:0] PWM_P_OUT,
  output logic      [7:0] PWM_M_OUT,
  output logic      [1:0] HP_P_OUT,
  output logic      [1:0] HP_M_OUT,
  output logic            SUPPLY_VOLUME_PWM_OUT,
  output logic      [7:0] HP_CFG_OUT
);
  pac_pkg::pac_state_t state;
  pac_pkg::pac_state_t next_state;
  logic [7:0]  lineout_config_a;
  logic [7:0]  lineout_config_b;
  logic [31:0] output_mixer_mode_control;
  logic [7:0]  pwm_channel_config;
  logic [7:0]  master_volume;
  logic [7:0]  master_ctrl;
  logic [7:0]  hp_config;
  logic [31:0] proc_config;
  logic [31:0] count;
  logic [2:0]  fault_low;
  logic        headphone_select_n_q;
  logic [7:0]  carrier;
  logic        in_reset;
  logic        bus_on;
  logic        fault_seen;
  logic        hp_change;
  logic        muted;
  logic        six_chan;
  logic        hp_mode;

  function automatic logic [1:0] drive(input pac_pkg::pac_chan_mode_t m, input logic half);
    case (m)
      pac_pkg::MODE_HALF: drive = {half, half};
      pac_pkg::MODE_PLAY: drive = {half, ~half};
      default:            drive = 2'b00;
    endcase
  endfunction : drive

  assign in_reset   = RST_IN || !CTRL.reset_n;
  // Registers answer only while powered and out of reset
  assign bus_on     = !in_reset && CTRL.power_down_n;
  assign fault_seen = fault_low == 3'(`PAC_FAULT_MIN_CYC);
  assign hp_change  = CTRL.headphone_select_n != headphone_select_n_q;
  assign muted      = master_ctrl[`PAC_MASTER_MUTE_BIT] || !CTRL.mute_n || master_volume == `PAC_VOL_MUTE;
  assign six_chan   = pwm_channel_config[`PAC_SIX_CHAN_BIT];
  assign hp_mode    = !CTRL.headphone_select_n;

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset) begin
      lineout_config_a          <= `PAC_LINEOUT_RST;
      lineout_config_b          <= `PAC_LINEOUT_RST;
      output_mixer_mode_control <= `PAC_MIXER_MODE_RST;
      pwm_channel_config        <= `PAC_CHAN_CFG_RST;
      master_volume             <= `PAC_VOL_MUTE;
      master_ctrl               <= 8'h00;
      hp_config                 <= `PAC_HP_CFG_RST;
      proc_config               <= `PAC_PROC_CFG_RST;
    end else if (bus_on && CTRL.reg_wr) begin
      // Writes during a back-end fault are kept, so settings survive it
      case (CTRL.reg_addr)
        `PAC_REG_LINEOUT_A:   lineout_config_a <= CTRL.reg_wdata[7:0];
        `PAC_REG_LINEOUT_B:   lineout_config_b <= CTRL.reg_wdata[7:0];
        `PAC_REG_MIXER_MODE:  output_mixer_mode_control <= CTRL.reg_wdata;
        `PAC_REG_CHAN_CFG:    pwm_channel_config <= CTRL.reg_wdata[7:0];
        `PAC_REG_MASTER_VOL:  master_volume <= CTRL.reg_wdata[7:0];
        `PAC_REG_MASTER_CTRL: master_ctrl <= CTRL.reg_wdata[7:0];
        `PAC_REG_HP_CFG:      hp_config <= CTRL.reg_wdata[7:0];
        `PAC_REG_PROC_CFG:    proc_config <= CTRL.reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset || !bus_on || !CTRL.reg_rd || state == pac_pkg::ST_FAULT) begin
      CTRL.reg_rdata <= 32'h0000_0000;
    end else begin
      case (CTRL.reg_addr)
        `PAC_REG_LINEOUT_A:   CTRL.reg_rdata <= {24'h000000, lineout_config_a};
        `PAC_REG_LINEOUT_B:   CTRL.reg_rdata <= {24'h000000, lineout_config_b};
        `PAC_REG_MIXER_MODE:  CTRL.reg_rdata <= output_mixer_mode_control;
        `PAC_REG_CHAN_CFG:    CTRL.reg_rdata <= {24'h000000, pwm_channel_config};
        `PAC_REG_MASTER_VOL:  CTRL.reg_rdata <= {24'h000000, master_volume};
        `PAC_REG_MASTER_CTRL: CTRL.reg_rdata <= {24'h000000, master_ctrl};
        `PAC_REG_HP_CFG:      CTRL.reg_rdata <= {24'h000000, hp_config};
        `PAC_REG_PROC_CFG:    CTRL.reg_rdata <= proc_config;
        `PAC_REG_STATUS:      CTRL.reg_rdata <= {26'h0000000, muted, fault_seen, state};
        default:              CTRL.reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Consecutive-low counter; short glitches on the fault line never start the fault sequence
  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset || CTRL.backend_fault_n) begin
      fault_low <= 3'h0;
    end else if (!fault_seen) begin
      fault_low <= fault_low + 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset) begin
      headphone_select_n_q <= 1'b1;
    end else if (state == pac_pkg::ST_RUN || state == pac_pkg::ST_INIT) begin
      headphone_select_n_q <= CTRL.headphone_select_n;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      pac_pkg::ST_RESET:      next_state = pac_pkg::ST_WAIT_TRIM;
      pac_pkg::ST_WAIT_TRIM:  if (CTRL.trim) next_state = pac_pkg::ST_INIT;
      pac_pkg::ST_INIT:       if (count >= 32'(INIT_CYC - 1)) next_state = pac_pkg::ST_RUN;
      pac_pkg::ST_RUN: begin
        if (fault_seen) begin
          next_state = pac_pkg::ST_FAULT;
        end else if (hp_change) begin
          next_state = pac_pkg::ST_HP_SOFT;
        end
      end
      // Release lands in the running state; fault and mute are then taken from the live inputs
      pac_pkg::ST_PDN:        next_state = pac_pkg::ST_RUN;
      pac_pkg::ST_FAULT:      if (CTRL.backend_fault_n) next_state = pac_pkg::ST_FAULT_WAIT;
      pac_pkg::ST_FAULT_WAIT: begin
        if (!CTRL.backend_fault_n) begin
          next_state = pac_pkg::ST_FAULT;
        end else if (count >= 32'(FAULT_WAIT_CYC - 1)) begin
          next_state = pac_pkg::ST_INIT;
        end
      end
      pac_pkg::ST_HP_SOFT:    if (count >= 32'(HP_STEP_CYC - 1)) next_state = pac_pkg::ST_HP_HARD;
      pac_pkg::ST_HP_HARD:    if (count >= 32'(HP_STEP_CYC - 1)) next_state = pac_pkg::ST_RUN;
      default:                next_state = pac_pkg::ST_RESET;
    endcase
    if (fault_seen && (state == pac_pkg::ST_INIT || state == pac_pkg::ST_HP_SOFT || state == pac_pkg::ST_HP_HARD)) begin
      next_state = pac_pkg::ST_FAULT;
    end
    if (!CTRL.power_down_n && state != pac_pkg::ST_RESET && state != pac_pkg::ST_WAIT_TRIM) begin
      next_state = pac_pkg::ST_PDN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset) begin
      state <= pac_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset || next_state != state) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

  // Carrier stops in power-down so nothing switches while the oscillator is off
  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset || state == pac_pkg::ST_PDN) begin
      carrier <= 8'h00;
    end else begin
      carrier <= carrier + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    logic [1:0]             pm;
    pac_pkg::pac_chan_mode_t spk;
    pac_pkg::pac_chan_mode_t hp;
    pac_pkg::pac_chan_mode_t line;
    pm   = 2'b00;
    spk  = pac_pkg::MODE_OFF;
    hp   = pac_pkg::MODE_OFF;
    line = pac_pkg::MODE_OFF;
    case (state)
      pac_pkg::ST_RUN: begin
        spk  = muted ? pac_pkg::MODE_HALF : pac_pkg::MODE_PLAY;
        line = spk;
        hp   = hp_mode ? spk : pac_pkg::MODE_OFF;
        if (hp_mode) spk = pac_pkg::MODE_OFF;
      end
      pac_pkg::ST_HP_SOFT: begin
        spk  = pac_pkg::MODE_HALF;
        hp   = pac_pkg::MODE_HALF;
        line = muted ? pac_pkg::MODE_HALF : pac_pkg::MODE_PLAY;
      end
      pac_pkg::ST_HP_HARD:    line = muted ? pac_pkg::MODE_HALF : pac_pkg::MODE_PLAY;
      pac_pkg::ST_FAULT, pac_pkg::ST_FAULT_WAIT: begin
        line = muted ? pac_pkg::MODE_HALF : pac_pkg::MODE_PLAY;
      end
      default: ;
    endcase
    // Lineouts 5 and 6 only stay independent in six-channel mode
    if (!six_chan) line = spk;
    for (int i = 0; i < 8; i++) begin
      pm = drive((i == 4 || i == 5) ? line : spk, carrier[7]);
      PWM_P_OUT[i] <= in_reset ? 1'b0 : pm[1];
      PWM_M_OUT[i] <= in_reset ? 1'b0 : pm[0];
    end
    for (int j = 0; j < 2; j++) begin
      pm = drive(hp, carrier[7]);
      HP_P_OUT[j] <= in_reset ? 1'b0 : pm[1];
      HP_M_OUT[j] <= in_reset ? 1'b0 : pm[0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset || state == pac_pkg::ST_PDN || state == pac_pkg::ST_RESET) begin
      SUPPLY_VOLUME_PWM_OUT <= 1'b0;
      CTRL.valid            <= 1'b0;
    end else begin
      SUPPLY_VOLUME_PWM_OUT <= carrier < ~master_volume;
      CTRL.valid            <= state == pac_pkg::ST_RUN || state == pac_pkg::ST_HP_SOFT
                               || state == pac_pkg::ST_HP_HARD;
    end
  end

  // Channels 1 and 2 take the headphone configuration while the headphone is selected
  always_ff @(posedge CORE_CLK_IN) begin
    if (in_reset) begin
      HP_CFG_OUT <= `PAC_HP_CFG_RST;
    end else begin
      HP_CFG_OUT <= hp_mode ? hp_config : lineout_config_a;
    end
  end
endmodule : pac_device

// ==== pac_defines.svh ====
// Register offsets, field positions, reset values and timing counts for the PWM audio state control
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

`define PAC_REG_LINEOUT_A    8'h09
`define PAC_REG_LINEOUT_B    8'h0a
`define PAC_REG_MIXER_MODE   8'hd0
`define PAC_REG_CHAN_CFG     8'he0
`define PAC_REG_MASTER_VOL   8'h10
`define PAC_REG_MASTER_CTRL  8'h11
`define PAC_REG_HP_CFG       8'h12
`define PAC_REG_PROC_CFG     8'h13
`define PAC_REG_STATUS       8'h14

`define PAC_MIXER_MODE_BIT   30
`define PAC_SIX_CHAN_BIT     1
`define PAC_MASTER_MUTE_BIT  0

`define PAC_LINEOUT_RST      8'he0
`define PAC_LINEOUT_SIX      8'h00
`define PAC_MIXER_MODE_RST   32'h0000_0000
`define PAC_CHAN_CFG_RST     8'h00
`define PAC_HP_CFG_RST       8'h00
`define PAC_VOL_MUTE         8'hff
// Fields: [1:0] in/out automute on, [4:2] thr1 (<8 bits), [7:5] thr2 = thr1, [11:8] modulation limit 93.7%,
// [12] manual bank, [13] tone bypass, [14] compressor bypass, [15] loudness off, [17:16] treble set 3,
// [19:18] bass set 3, [20] AM avoid off, [21] IF 455 kHz, [23:22] select seq 1, [24] BCD, tuned freq 0000,
// [27:26] serial format I2S 24-bit, [28] hard unmute after clock error
`define PAC_PROC_CFG_RST     32'h114f_7503

`define PAC_CLK_KHZ          10000
`define PAC_AUTOMUTE_DELAY_US 14900
`define PAC_VOL_RAMP_US      42600
`define PAC_TONE_SLEW_US     1310
`define PAC_FAULT_WAIT_US    5000
`define PAC_FAULT_WAIT_CYC   ((`PAC_FAULT_WAIT_US * `PAC_CLK_KHZ) / 1000)
`define PAC_FAULT_MIN_CYC    5
`define PAC_PDN_SETUP_CYC    5
`define PAC_INIT_CYC         256
`define PAC_HP_STEP_CYC      64

`endif

// ==== pac_pkg.sv ====
// Types used by the device end of the PWM audio state control
package pac_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_WAIT_TRIM, ST_INIT, ST_RUN, ST_PDN, ST_FAULT, ST_FAULT_WAIT, ST_HP_SOFT, ST_HP_HARD
  } pac_state_t;
  typedef enum logic [1:0] {MODE_OFF, MODE_HALF, MODE_PLAY} pac_chan_mode_t;
endpackage : pac_pkg

// ==== pac_ctrl_if.sv ====
// Control terminals and register port between system controller and audio processor
`timescale 1ns/1ns
interface pac_ctrl_if;
  logic        reset_n;
  logic        power_down_n;
  logic        backend_fault_n;
  logic        headphone_select_n;
  logic        mute_n;
  logic        trim;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        valid;
  modport dev (input reset_n, power_down_n, backend_fault_n, headphone_select_n, mute_n, trim,
               input reg_addr, reg_wdata, reg_wr, reg_rd, output reg_rdata, valid);
  modport host (output reset_n, power_down_n, backend_fault_n, headphone_select_n, mute_n, trim,
                output reg_addr, reg_wdata, reg_wr, reg_rd, input reg_rdata, valid);
endinterface : pac_ctrl_if

// ==== pac_host.sv ====
// Controller end: drives control terminals and forwards register accesses from software
`timescale 1ns/1ns
`include "pac_defines.svh"
module pac_host (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  pac_ctrl_if.host         CTRL,
  input  wire logic [7:0]  SW_ADDR_IN,
  input  wire logic [31:0] SW_WDATA_IN,
  input  wire logic        SW_WR_IN,
  input  wire logic        SW_RD_IN,
  output logic      [31:0] SW_RDATA_OUT,
  input  wire logic        BACKEND_FAULT_N_IN
);
  // Host map: 0x00 pins {mute_n, headphone_select_n, pdn_n, reset_n}, 0x04 dev addr, 0x08 dev wdata (write sends),
  // 0x0c dev rdata (write reads), 0x10 status, 0x14 six-channel setup (write starts)
  logic [3:0]  pins;
  logic [7:0]  dev_addr;
  logic [31:0] dev_rdata;
  logic [2:0]  pdn_wait;
  logic [2:0]  stretch;
  logic [1:0]  six_step;
  logic        dev_rd_q;
  logic        reset_q;
  logic        rel_q;
  logic        trim_sent;
  logic        hp_q;
  logic        six_mode;
  logic        mute_pulse;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      pins     <= 4'h2;
      dev_addr <= 8'h00;
    end else if (SW_WR_IN && SW_ADDR_IN == 8'h00) begin
      pins <= SW_WDATA_IN[3:0];
    end else if (SW_WR_IN && SW_ADDR_IN == 8'h04) begin
      dev_addr <= SW_WDATA_IN[7:0];
    end
  end

  // Power-down release held until five clocks have run with the request standing
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !pins[1]) begin
      pdn_wait <= 3'h0;
    end else if (pdn_wait != 3'(`PAC_PDN_SETUP_CYC)) begin
      pdn_wait <= pdn_wait + 3'h1;
    end
  end

  // Stretch each fault so the device sees at least five low cycles
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      stretch <= 3'h0;
    end else if (!BACKEND_FAULT_N_IN) begin
      stretch <= 3'(`PAC_FAULT_MIN_CYC);
    end else if (stretch != 3'h0) begin
      stretch <= stretch - 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      reset_q <= 1'b0;
      rel_q   <= 1'b0;
      hp_q    <= 1'b1;
    end else begin
      reset_q <= pins[0];
      rel_q   <= reset_q;
      hp_q    <= pins[2];
    end
  end

  // Trim waits until the device is out of reset and powered, else the pulse is lost
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !rel_q) begin
      trim_sent <= 1'b0;
    end else if (CTRL.trim) begin
      trim_sent <= 1'b1;
    end
  end

  // Track six-channel remapped mode to know when a headphone change needs a mute pulse
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !pins[0]) begin
      six_mode <= 1'b0;
    end else if (CTRL.reg_wr && CTRL.reg_addr == `PAC_REG_CHAN_CFG) begin
      six_mode <= CTRL.reg_wdata[`PAC_SIX_CHAN_BIT];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      mute_pulse <= 1'b0;
    end else begin
      mute_pulse <= hp_q != pins[2] && six_mode;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      six_step <= 2'h0;
    end else if (six_step != 2'h0) begin
      six_step <= six_step + 2'h1;
    end else if (SW_WR_IN && SW_ADDR_IN == 8'h14) begin
      six_step <= 2'h1;
    end
  end

  always_comb begin
    CTRL.reset_n            = reset_q;
    CTRL.power_down_n       = pins[1] && pdn_wait == 3'(`PAC_PDN_SETUP_CYC);
    CTRL.headphone_select_n = hp_q;
    CTRL.mute_n             = pins[3] && !mute_pulse;
    CTRL.backend_fault_n    = BACKEND_FAULT_N_IN && stretch == 3'h0;
    CTRL.trim               = rel_q && CTRL.power_down_n && !trim_sent;
    CTRL.reg_rd             = SW_WR_IN && SW_ADDR_IN == 8'h0c && six_step == 2'h0;
    CTRL.reg_wr             = (SW_WR_IN && SW_ADDR_IN == 8'h08) || six_step != 2'h0;
    CTRL.reg_addr           = dev_addr;
    CTRL.reg_wdata          = SW_WDATA_IN;
    case (six_step)
      2'h1: begin
        CTRL.reg_addr  = `PAC_REG_LINEOUT_A;
        CTRL.reg_wdata = {24'h000000, `PAC_LINEOUT_SIX};
      end
      2'h2: begin
        CTRL.reg_addr  = `PAC_REG_LINEOUT_B;
        CTRL.reg_wdata = {24'h000000, `PAC_LINEOUT_SIX};
      end
      2'h3: begin
        CTRL.reg_addr  = `PAC_REG_CHAN_CFG;
        CTRL.reg_wdata = 32'h0000_0002;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      dev_rd_q  <= 1'b0;
      dev_rdata <= 32'h0000_0000;
    end else begin
      dev_rd_q <= CTRL.reg_rd;
      if (dev_rd_q) dev_rdata <= CTRL.reg_rdata;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !SW_RD_IN) begin
      SW_RDATA_OUT <= 32'h0000_0000;
    end else begin
      case (SW_ADDR_IN)
        8'h00:   SW_RDATA_OUT <= {28'h0000000, pins};
        8'h04:   SW_RDATA_OUT <= {24'h000000, dev_addr};
        8'h0c:   SW_RDATA_OUT <= dev_rdata;
        8'h10:   SW_RDATA_OUT <= {28'h0000000, six_step != 2'h0, six_mode, !CTRL.backend_fault_n, CTRL.valid};
        default: SW_RDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end
endmodule : pac_host

// ==== pac_ctrl_asserts.sv ====
// Checker on the control terminals and register port between the two ends
`timescale 1ns/1ns
module pac_ctrl_asserts #(
  parameter int FAULT_WAIT_CYC = 20,
  parameter int INIT_CYC       = 8
) (
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        reset_n,
  input wire logic        power_down_n,
  input wire logic        backend_fault_n,
  input wire logic        headphone_select_n,
  input wire logic        mute_n,
  input wire logic        trim,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        valid
);
  logic [2:0] pdn_lo;
  logic [7:0] up_cnt;
  logic       flt;
  logic       six;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  // Counts from the end of bench reset, so the count is never unknown
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || power_down_n) pdn_lo <= 3'h0;
    else if (pdn_lo != 3'h7) pdn_lo <= pdn_lo + 3'h1;
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !backend_fault_n) up_cnt <= 8'h00;
    else if (up_cnt != 8'hff) up_cnt <= up_cnt + 8'h01;
  end
  // Only a return from fault is timed, not start-up or power-down exit
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !reset_n || $rose(valid)) flt <= 1'b0;
    else if (!backend_fault_n) flt <= 1'b1;
  end
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || !reset_n) six <= 1'b0;
    else if (reg_wr && reg_addr == 8'he0) six <= reg_wdata[1];
  end
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_rdata_blocked: assert property (reg_rd && (!reset_n || !power_down_n) |=> reg_rdata == 32'h0)
    else $error("read answered while blocked");
  a_byte_regs: assert property (reg_rd && reg_addr inside {8'h09, 8'h0a, 8'he0} |=> reg_rdata[31:8] == 24'h0)
    else $error("byte register upper bits set");
  a_valid_reset: assert property (!reset_n [*2] |=> !valid)
    else $error("valid high in reset");
  a_valid_pdn: assert property (!power_down_n [*3] |=> !valid)
    else $error("valid high in power-down");
  a_fault_valid: assert property (!backend_fault_n [*6] |-> ##2 !valid)
    else $error("valid high in fault");
  a_trim_pulse: assert property (trim |=> !trim && reset_n)
    else $error("trim not a pulse at reset release");
  a_pdn_setup: assert property ($rose(power_down_n) |-> pdn_lo >= 3'h5)
    else $error("power-down released too early");
  a_fault_wait: assert property ($rose(valid) && flt |->
    int'(up_cnt) inside {[FAULT_WAIT_CYC + INIT_CYC : FAULT_WAIT_CYC + INIT_CYC + 12]})
    else $error("fault recovery time wrong");
  a_mute_pulse: assert property (six && $changed(headphone_select_n) |-> ##[0:2] !mute_n)
    else $error("no mute pulse after select change");
endmodule : pac_ctrl_asserts

// ==== pwm_audio_pin_state_control_bench.sv ====
// Bench joining controller and device ends through the control interface
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pwm_audio_pin_state_control_bench;
  localparam int FW = 20;
  localparam int IW = 8;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} pac_row_t;
  logic        clk, rst, wr_s, rd_s, fault_n, supply;
  logic [7:0]  addr, pwm_p, pwm_m, hp_cfg;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  hp_p, hp_m;
  int          miscompares, total_checks, n, k;
  pac_row_t    rows [11] = '{{1'b0, 8'h09, 32'h0, 32'he0}, {1'b0, 8'h0a, 32'h0, 32'he0},
    {1'b0, 8'hd0, 32'h0, 32'h0}, {1'b0, 8'he0, 32'h0, 32'h0}, {1'b0, 8'h10, 32'h0, 32'hff},
    {1'b0, 8'h13, 32'h0, 32'h114f7503}, {1'b0, 8'h12, 32'h0, 32'h0}, {1'b0, 8'hff, 32'h0, 32'h0},
    {1'b1, 8'h12, 32'h5a, 32'h5a}, {1'b1, 8'h09, 32'hffffff33, 32'h33}, {1'b1, 8'h10, 32'h20, 32'h20}};
  pac_ctrl_if ifc ();
  pac_host pac_host_inst (.CORE_CLK_IN(clk), .RST_IN(rst), .CTRL(ifc), .SW_ADDR_IN(addr),
    .SW_WDATA_IN(wdata), .SW_WR_IN(wr_s), .SW_RD_IN(rd_s), .SW_RDATA_OUT(rdata), .BACKEND_FAULT_N_IN(fault_n));
  pac_device #(.FAULT_WAIT_CYC(FW), .INIT_CYC(IW), .HP_STEP_CYC(4)) pac_device_inst (.CORE_CLK_IN(clk),
    .RST_IN(rst), .CTRL(ifc), .PWM_P_OUT(pwm_p), .PWM_M_OUT(pwm_m), .HP_P_OUT(hp_p), .HP_M_OUT(hp_m),
    .SUPPLY_VOLUME_PWM_OUT(supply), .HP_CFG_OUT(hp_cfg));
  pac_ctrl_asserts #(.FAULT_WAIT_CYC(FW), .INIT_CYC(IW)) pac_ctrl_asserts_inst (.CORE_CLK_IN(clk),
    .RST_IN(rst), .reset_n(ifc.reset_n), .power_down_n(ifc.power_down_n), .backend_fault_n(ifc.backend_fault_n),
    .headphone_select_n(ifc.headphone_select_n), .mute_n(ifc.mute_n), .trim(ifc.trim), .reg_addr(ifc.reg_addr),
    .reg_wdata(ifc.reg_wdata), .reg_wr(ifc.reg_wr), .reg_rd(ifc.reg_rd), .reg_rdata(ifc.reg_rdata),
    .valid(ifc.valid));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : cyc
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 rd = rdata;
  endtask : sw_rd
  // Device registers are reached only through the controller's forwarding window
  task automatic dev_wr(input logic [7:0] a, input logic [31:0] d);
    sw_wr(8'h04, {24'h0, a});
    sw_wr(8'h08, d);
  endtask : dev_wr
  task automatic dev_rd(input logic [7:0] a);
    sw_wr(8'h04, {24'h0, a});
    sw_wr(8'h0c, 32'h0);
    cyc(2);
    sw_rd(8'h0c);
  endtask : dev_rd
  task automatic wait_valid;
    n = 0;
    while (ifc.valid !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    #1;
    `CHK(ifc.valid, 1'b1)
  endtask : wait_valid
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    {rst, wr_s, rd_s, fault_n, addr, wdata} = {4'h9, 40'h0};
    {miscompares, total_checks} = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    sw_wr(8'h00, 32'hf);
    wait_valid;
    `CHK(pwm_m, pwm_p)
    foreach (rows[i]) begin
      if (rows[i].wr)
        dev_wr(rows[i].a, rows[i].d);
      dev_rd(rows[i].a);
      `CHK(rd, rows[i].e)
    end
    cyc(3);
    `CHK(pwm_m, ~pwm_p)
    for (k = 0; k < 2; k++) begin
      if (k == 0)
        dev_wr(8'h11, 32'h1);
      else
        sw_wr(8'h00, 32'h7);
      cyc(3);
      `CHK(pwm_m, pwm_p)
      sw_wr(8'h00, 32'hf);
      dev_wr(8'h11, 32'h0);
      cyc(3);
      `CHK(pwm_m, ~pwm_p)
    end
    sw_wr(8'h00, 32'hb);
    cyc(3);
    repeat (5) begin
      `CHK({hp_m, pwm_m}, {hp_p, pwm_p})
      cyc(1);
    end
    cyc(10);
    `CHK(hp_m, ~hp_p)
    `CHK({pwm_p[1:0], pwm_m[1:0], hp_cfg}, 12'h05a)
    sw_wr(8'h00, 32'hf);
    cyc(14);
    `CHK({hp_p, hp_m}, 4'h0)
    sw_wr(8'h14, 32'h0);
    cyc(4);
    dev_rd(8'h09);
    `CHK(rd, 32'h0)
    dev_rd(8'he0);
    `CHK(rd, 32'h2)
    // Select change in six-channel mode makes the controller pulse mute
    sw_wr(8'h00, 32'hb);
    cyc(5);
    `CHK(pwm_m[5:4], ~pwm_p[5:4])
    cyc(15);
    sw_wr(8'h00, 32'hf);
    cyc(20);
    @(posedge clk);
    fault_n <= 1'b0;
    cyc(12);
    `CHK(ifc.valid, 1'b0)
    `CHK({pwm_p[7:6], pwm_p[3:0], pwm_m[7:6], pwm_m[3:0], hp_p, hp_m}, 16'h0)
    `CHK(pwm_m[5:4], ~pwm_p[5:4])
    @(posedge clk);
    fault_n <= 1'b1;
    wait_valid;
    `CHK(n >= FW + IW && n <= FW + IW + 12, 1'b1)
    dev_rd(8'h12);
    `CHK(rd, 32'h5a)
    sw_wr(8'h00, 32'hd);
    cyc(3);
    `CHK({ifc.valid, pwm_p, pwm_m, supply}, 18'h0)
    dev_wr(8'h10, 32'h44);
    dev_rd(8'h10);
    `CHK(rd, 32'h0)
    sw_wr(8'h00, 32'hf);
    wait_valid;
    dev_rd(8'h10);
    `CHK(rd, 32'h20)
    `CHK(pwm_m, ~pwm_p)
    sw_wr(8'h00, 32'he);
    cyc(3);
    `CHK({ifc.valid, pwm_p, pwm_m}, 17'h0)
    sw_wr(8'h00, 32'hf);
    wait_valid;
    `CHK(pwm_m, pwm_p)
    dev_rd(8'h10);
    `CHK(rd, 32'hff)
    dev_rd(8'he0);
    `CHK(rd, 32'h0)
    summarize();
  end
endmodule : pwm_audio_pin_state_control_bench
